/* File: bmmr_host_model.sv */
`default_nettype none
module bmmr_host_model (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  output bmmr_pkg::bmmr_byte_t rx_out,
  output logic tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import bmmr_pkg::*;
  initial rx_out = '0;
  initial tx_ready_out = 1'b1;
  // host drains at its own pace
  always @(posedge sys_clk_in) begin
    tx_ready_out <= rst_in ? 1'b1 : ($urandom_range(3) != 0);
  end
  // Idle data line shows the inverse so stale bytes are never mistaken
  task automatic req(input logic [7:0] b0, input logic [7:0] b1);
    @(posedge sys_clk_in);
    rx_out <= '{1'b1, b0};
    @(posedge sys_clk_in);
    rx_out <= '{1'b1, b1};
    @(posedge sys_clk_in);
    rx_out <= '{1'b0, ~b1};
  endtask
endmodule // bmmr_host_model
`default_nettype wire

/* File: bmmr_pkg.sv */
`default_nettype none
package bmmr_pkg;
  localparam logic [7:0] REQ_LEAD = 8'ha5;
  localparam logic [7:0] REQ_DEFN = 8'hc0;
  localparam logic [7:0] REQ_MCFG = 8'hc1;
  localparam logic [7:0] REQ_MDAT = 8'hd1;
  localparam logic [7:0] REQ_ACK = 8'hb9;
  localparam logic [7:0] REQ_OCFG = 8'hce;

  // Block lengths include the lead byte, code, length byte and checksum
  localparam logic [7:0] LEN_DEFN = 8'h2a;
  localparam logic [7:0] LEN_MCFG = 8'h94;
  localparam logic [7:0] LEN_MDAT = 8'ha6;
  localparam logic [7:0] LEN_OCFG = 8'h3c;

  // Configuration block layout
  localparam logic [7:0] MCFG_CHAN_BASE = 8'h10;
  localparam logic [7:0] MCFG_CHAN_SIZE = 8'h0a;
  localparam logic [7:0] MCFG_CALC_BASE = 8'h6a;
  localparam logic [7:0] MCFG_CALC_SIZE = 8'h0e;
  localparam logic [7:0] MCFG_SF_BASE = 8'h86;
  localparam logic [7:0] MCFG_SF_END = 8'h92;
  localparam int NUM_CHAN = 9;
  localparam int NUM_SF = 3;

  // Operate configuration layout
  localparam logic [7:0] OCFG_RB_BASE = 8'h0a;
  localparam logic [7:0] OCFG_RB_END = 8'h3a;

  // Data block layout
  localparam logic [7:0] MDAT_STATUS_IDX = 8'h03;
  localparam logic [7:0] MDAT_PAY_BASE = 8'h04;
  localparam int PAY_BYTES = 160;
  localparam logic [7:0] MDAT_PAY_END = 8'ha4;

  // Status byte bit positions
  localparam int ST_WARN_BIT = 2;
  localparam int ST_FAIL_BIT = 3;
  localparam int ST_SET_BIT = 4;

  // Register map, byte addresses
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_SF_I = 10'h004;
  localparam logic [ADDR_W-1:0] ADDR_SF_X = 10'h008;
  localparam logic [ADDR_W-1:0] ADDR_SF_Y = 10'h00c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 10'h010;
  localparam logic [ADDR_W-1:0] ADDR_PAY_BASE = 10'h100;
  localparam int CTRL_PHASE_ROTATION_BIT = 0;
  localparam int STATUS_BUSY_BIT = 8;

  typedef enum logic [2:0] {BLK_NONE, BLK_DEFN, BLK_MCFG, BLK_MDAT, BLK_OCFG} bmmr_blk_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } bmmr_byte_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } bmmr_bus_t;
endpackage : bmmr_pkg
`default_nettype wire

/* File: bmmr_responder.sv */
`default_nettype none
// Summary of operation
// RQ1: Definition request answers 2A-long definition block
// RQ2: Definition declares protocols, message, flags, codes
// RQ3: Flag entries: status query strings, reconfigure request
// RQ4: Every block ends with byte-sum checksum
// RQ5: Protocol capability words 0100, 0101, 0005
// RQ6: Configuration block length 94, counts declared
// RQ7: Channel descriptor: name, integer, float, offset
// RQ8: First calc block: rotation, type 00, indices
// RQ9: Second calc block: type 02, FFFF, voltages
// RQ10: Three four-byte float scale factors sent
// RQ11: Data block length A6 with payload layout
// RQ12: Samples in fixed channel order, integers
// RQ13: Acknowledge request clears the status byte
// RQ14: Status bits 2 warn, 3 fail, 4 settings
// RQ15: Diagnostics pass clears warn and fail only
// RQ16: Acknowledge leaves internal self-test condition alone
// RQ17: Host rereads configuration after settings flag
// RQ18: Operate config length 3C, breaker, sixteen bits
// RQ19: Operate codes 31, 11, 00/20/40 plus n
// RQ20: Binary answers interleave with ASCII stream
// RQ21: Only listed request codes get any answer
module bmmr_responder (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire bmmr_pkg::bmmr_bus_t bus_in,
  output logic [31:0] bus_rdata_out,
  input wire bmmr_pkg::bmmr_byte_t rx_in,
  input wire bmmr_pkg::bmmr_byte_t ascii_in,
  output logic ascii_ready_out,
  output bmmr_pkg::bmmr_byte_t tx_out,
  input wire logic tx_ready_in,
  input wire logic selftest_warning_in,
  input wire logic selftest_failure_in,
  input wire logic diag_pass_in,
  input wire logic settings_change_in,
  output logic [7:0] status_byte_out
);
  import bmmr_pkg::*;

  typedef struct packed {
    logic lead_seen;
    bmmr_blk_t blk;
    logic [7:0] idx;
    logic [7:0] len;
    logic [7:0] cksum;
    bmmr_byte_t tx;
    logic ascii_ready;
    logic selftest_warning_flag;
    logic selftest_failure_flag;
    logic settings_changed_flag;
    logic warn_prev;
    logic fail_prev;
    logic phase_rotation;
    logic [NUM_SF-1:0][31:0] sf;
    logic [PAY_BYTES-1:0][7:0] pay;
    logic [31:0] rdata;
  } bmmr_state_t;

  bmmr_state_t st_q, st_d;

  function automatic logic [7:0] defn_byte(input logic [7:0] i);
    logic [7:0] b;
    b = 8'h00;
    // RQ2 RQ3 RQ5 definition table entries
    case (i)
      8'h00, 8'h06, 8'h08, 8'h1c: b = 8'ha5;
      8'h01: b = REQ_DEFN;
      8'h02: b = LEN_DEFN;
      8'h03, 8'h0b: b = 8'h02;
      8'h04, 8'h22, 8'h24, 8'h25: b = 8'h01;
      8'h05, 8'h13: b = 8'h03;
      8'h07, 8'h1d: b = 8'hc1;
      8'h09: b = 8'hd1;
      8'h0c, 8'h14: b = 8'h53;
      8'h0d, 8'h15: b = 8'h54;
      8'h0e, 8'h16: b = 8'h41;
      8'h0f, 8'h17: b = 8'h0d;
      8'h1b: b = 8'h04;
      8'h27: b = 8'h05;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  function automatic logic [7:0] chan_byte(input logic [7:0] ch, input logic [7:0] pos);
    logic [7:0] b;
    logic [7:0] phase;
    logic [7:0] role;
    b = 8'h00;
    phase = ch / 8'd3;
    role = ch % 8'd3;
    case (pos)
      8'h00: b = (role == 8'd1) ? 8'h49 : 8'h56;
      8'h01: b = 8'h41 + phase;
      8'h02: b = (role == 8'd0) ? 8'h58 : ((role == 8'd2) ? 8'h59 : 8'h00);
      8'h07: b = 8'h01;
      8'h09: b = (role == 8'd0) ? 8'h8a : ((role == 8'd1) ? 8'h86 : 8'h8e);
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  function automatic logic [7:0] calc_byte(input logic [7:0] k, input logic second, input logic rot);
    logic [7:0] b;
    b = 8'hff;
    case (k)
      8'h00: b = {7'h00, rot};
      8'h01: b = second ? 8'h02 : 8'h00;
      8'h08: b = second ? 8'hff : 8'h01;
      8'h09: b = second ? 8'hff : 8'h04;
      8'h0a: b = second ? 8'hff : 8'h07;
      8'h0b: b = second ? 8'h02 : 8'h00;
      8'h0c: b = second ? 8'h05 : 8'h03;
      8'h0d: b = second ? 8'h08 : 8'h06;
      default: b = 8'hff;
    endcase
    return b;
  endfunction

  function automatic logic [7:0] mcfg_byte(input logic [7:0] i, input logic rot, input logic [NUM_SF-1:0][31:0] sf);
    logic [7:0] b;
    logic [7:0] j;
    logic [7:0] s;
    b = 8'h00;
    j = 8'h00;
    s = 8'h00;
    if (i < MCFG_CHAN_BASE) begin
      case (i)
        8'h00: b = 8'ha5;
        8'h01: b = REQ_MCFG;
        8'h02: b = LEN_MCFG;
        8'h03, 8'h04: b = 8'h01;
        8'h05: b = 8'h03;
        8'h06: b = 8'h09;
        8'h07, 8'h0b: b = 8'h04;
        8'h08: b = 8'h50;
        8'h09: b = 8'h02;
        8'h0d: b = 8'h4c;
        8'h0f: b = 8'h54;
        default: b = 8'h00;
      endcase
    end else if (i < MCFG_CALC_BASE) begin
      j = i - MCFG_CHAN_BASE;
      // RQ7 channel descriptor
      b = chan_byte(j / MCFG_CHAN_SIZE, j % MCFG_CHAN_SIZE);
    end else if (i < MCFG_SF_BASE) begin
      j = i - MCFG_CALC_BASE;
      if (j < MCFG_CALC_SIZE) begin
        // RQ8 six-channel calc
        b = calc_byte(j, 1'b0, rot);
      end else begin
        // RQ9 voltage-only calc
        b = calc_byte(j - MCFG_CALC_SIZE, 1'b1, rot);
      end
    end else if (i < MCFG_SF_END) begin
      j = i - MCFG_SF_BASE;
      s = j >> 2;
      // RQ10 scale factors, MSB first
      b = sf[s[1:0]][(8'd3 - j[1:0]) * 8 +: 8];
    end
    return b;
  endfunction

  function automatic logic [7:0] ocfg_byte(input logic [7:0] i);
    logic [7:0] b;
    logic [7:0] j;
    b = 8'h00;
    j = i - OCFG_RB_BASE;
    if (i >= OCFG_RB_BASE && i < OCFG_RB_END) begin
      // RQ19 clear, set, pulse per remote bit
      b = {1'b0, j % 8'd3 == 8'd2, j % 8'd3 == 8'd1, 1'b0, 4'(j / 8'd3)};
    end else begin
      case (i)
        8'h00: b = 8'ha5;
        8'h01: b = REQ_OCFG;
        8'h02: b = LEN_OCFG;
        8'h03, 8'h06: b = 8'h01;
        8'h05: b = 8'h10;
        8'h08: b = 8'h31;
        8'h09: b = 8'h11;
        default: b = 8'h00;
      endcase
    end
    return b;
  endfunction

  logic [7:0] status_now;
  logic [7:0] gen_byte;
  logic slot_free;
  logic [ADDR_W-1:0] pay_off;
  logic [7:0] pay_idx;

  always_comb begin
    // RQ14 status layout
    status_now = 8'h00;
    status_now[ST_WARN_BIT] = st_q.selftest_warning_flag;
    status_now[ST_FAIL_BIT] = st_q.selftest_failure_flag;
    status_now[ST_SET_BIT] = st_q.settings_changed_flag;
    pay_idx = st_q.idx - MDAT_PAY_BASE;
    case (st_q.blk)
      BLK_DEFN: gen_byte = defn_byte(st_q.idx);
      BLK_MCFG: gen_byte = mcfg_byte(st_q.idx, st_q.phase_rotation, st_q.sf);
      BLK_OCFG: gen_byte = ocfg_byte(st_q.idx);
      BLK_MDAT: begin
        // RQ11 data block fields
        if (st_q.idx == 8'h00) begin
          gen_byte = REQ_LEAD;
        end else if (st_q.idx == 8'h01) begin
          gen_byte = REQ_MDAT;
        end else if (st_q.idx == 8'h02) begin
          gen_byte = LEN_MDAT;
        end else if (st_q.idx == MDAT_STATUS_IDX) begin
          gen_byte = status_now;
        end else if (st_q.idx < MDAT_PAY_END) begin
          // RQ12 samples as stored, sample-major
          gen_byte = st_q.pay[pay_idx];
        end else begin
          gen_byte = 8'h00;
        end
      end
      default: gen_byte = 8'h00;
    endcase
    slot_free = !st_q.tx.valid || tx_ready_in;
    pay_off = bus_in.addr - ADDR_PAY_BASE;
  end

  always_comb begin
    st_d = st_q;
    st_d.rdata = 32'h0000_0000;
    if (tx_ready_in) begin
      st_d.tx.valid = 1'b0;
    end

    // RQ20 ASCII byte taken only while no block is in flight
    if (ascii_in.valid && st_q.ascii_ready) begin
      st_d.tx.valid = 1'b1;
      st_d.tx.data = ascii_in.data;
    end else if (st_q.blk != BLK_NONE && slot_free) begin
      st_d.tx.valid = 1'b1;
      if (st_q.idx == st_q.len - 8'd1) begin
        // RQ4 checksum closes block
        st_d.tx.data = st_q.cksum;
        st_d.blk = BLK_NONE;
      end else begin
        st_d.tx.data = gen_byte;
        st_d.cksum = st_q.cksum + gen_byte;
        st_d.idx = st_q.idx + 8'd1;
      end
    end

    // Self-test flags latch on a new condition; a steady condition cannot refill them
    st_d.warn_prev = selftest_warning_in;
    st_d.fail_prev = selftest_failure_in;
    // RQ15 diagnostics pass clears warn and fail
    if (diag_pass_in) begin
      st_d.selftest_warning_flag = 1'b0;
      st_d.selftest_failure_flag = 1'b0;
    end

    // RQ21 two-byte request decode; stray bytes are dropped
    if (rx_in.valid) begin
      st_d.lead_seen = (rx_in.data == REQ_LEAD);
      if (st_q.lead_seen && st_q.blk == BLK_NONE) begin
        st_d.idx = 8'h00;
        st_d.cksum = 8'h00;
        case (rx_in.data)
          REQ_DEFN: begin
            // RQ1 definition block
            st_d.blk = BLK_DEFN;
            st_d.len = LEN_DEFN;
          end
          REQ_MCFG: begin
            // RQ6 configuration block
            st_d.blk = BLK_MCFG;
            st_d.len = LEN_MCFG;
          end
          REQ_MDAT: begin
            st_d.blk = BLK_MDAT;
            st_d.len = LEN_MDAT;
          end
          REQ_OCFG: begin
            // RQ18 operate configuration
            st_d.blk = BLK_OCFG;
            st_d.len = LEN_OCFG;
          end
          REQ_ACK: begin
            // RQ13 acknowledge clears status byte
            // RQ16 inputs untouched, only flags
            st_d.selftest_warning_flag = 1'b0;
            st_d.selftest_failure_flag = 1'b0;
            st_d.settings_changed_flag = 1'b0;
          end
          default: st_d.blk = BLK_NONE;
        endcase
      end
    end

    // Control and scale factor register writes count as a settings change; payload writes do not
    if (bus_in.we) begin
      case (bus_in.addr)
        ADDR_CTRL: begin
          st_d.phase_rotation = bus_in.wdata[CTRL_PHASE_ROTATION_BIT];
          st_d.settings_changed_flag = 1'b1;
        end
        ADDR_SF_I: begin
          st_d.sf[0] = bus_in.wdata;
          st_d.settings_changed_flag = 1'b1;
        end
        ADDR_SF_X: begin
          st_d.sf[1] = bus_in.wdata;
          st_d.settings_changed_flag = 1'b1;
        end
        ADDR_SF_Y: begin
          st_d.sf[2] = bus_in.wdata;
          st_d.settings_changed_flag = 1'b1;
        end
        default: begin
          if (bus_in.addr >= ADDR_PAY_BASE && pay_off[ADDR_W-1:2] < ADDR_W'(PAY_BYTES)) begin
            st_d.pay[pay_off[ADDR_W-1:2]] = bus_in.wdata[7:0];
          end
        end
      endcase
    end
    if (bus_in.re) begin
      case (bus_in.addr)
        ADDR_CTRL: st_d.rdata[CTRL_PHASE_ROTATION_BIT] = st_q.phase_rotation;
        ADDR_SF_I: st_d.rdata = st_q.sf[0];
        ADDR_SF_X: st_d.rdata = st_q.sf[1];
        ADDR_SF_Y: st_d.rdata = st_q.sf[2];
        ADDR_STATUS: begin
          st_d.rdata[7:0] = status_now;
          st_d.rdata[STATUS_BUSY_BIT] = (st_q.blk != BLK_NONE);
        end
        default: begin
          if (bus_in.addr >= ADDR_PAY_BASE && pay_off[ADDR_W-1:2] < ADDR_W'(PAY_BYTES)) begin
            st_d.rdata[7:0] = st_q.pay[pay_off[ADDR_W-1:2]];
          end
        end
      endcase
    end

    // Sets come last so an event in the clearing cycle is kept
    if (selftest_warning_in && !st_q.warn_prev) begin
      st_d.selftest_warning_flag = 1'b1;
    end
    if (selftest_failure_in && !st_q.fail_prev) begin
      st_d.selftest_failure_flag = 1'b1;
    end
    if (settings_change_in) begin
      st_d.settings_changed_flag = 1'b1;
    end
    st_d.ascii_ready = (st_d.blk == BLK_NONE) && !st_d.tx.valid;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_q <= '0;
      // Power-up counts as a settings change
      st_q.settings_changed_flag <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus_rdata_out = st_q.rdata;
  assign tx_out = st_q.tx;
  assign ascii_ready_out = st_q.ascii_ready;
  assign status_byte_out = {3'h0, st_q.settings_changed_flag, st_q.selftest_failure_flag,
                            st_q.selftest_warning_flag, 2'h0};
endmodule // bmmr_responder
`default_nettype wire

/* File: bmmr_responder_properties.sv */
`default_nettype none
module bmmr_responder_checker import bmmr_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire bmmr_pkg::bmmr_bus_t bus_in,
  input wire logic [31:0] bus_rdata_out,
  input wire bmmr_pkg::bmmr_byte_t rx_in,
  input wire bmmr_pkg::bmmr_byte_t ascii_in,
  input wire logic ascii_ready_out,
  input wire bmmr_pkg::bmmr_byte_t tx_out,
  input wire logic tx_ready_in,
  input wire logic selftest_warning_in,
  input wire logic selftest_failure_in,
  input wire logic diag_pass_in,
  input wire logic settings_change_in,
  input wire logic [7:0] status_byte_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Only requests taken while idle count; busy-time requests are dropped
  sequence s_req(logic [7:0] c);
    rx_in.valid && rx_in.data == REQ_LEAD && ascii_ready_out ##1 rx_in.valid && rx_in.data == c;
  endsequence
  chk_rdata_idle: assert property (!$past(bus_in.re) |-> bus_rdata_out == 32'h0)
    else $error("read data not zero outside read cycle");
  chk_tx_hold: assert property (tx_out.valid && !tx_ready_in |=> tx_out.valid && $stable(tx_out.data))
    else $error("tx byte changed while stalled");
  chk_ascii_gate: assert property (ascii_ready_out |-> !tx_out.valid)
    else $error("ascii ready while tx slot busy");
  chk_ack_clear: assert property (s_req(REQ_ACK) ##0 !settings_change_in && !$rose(selftest_warning_in)
    && !$rose(selftest_failure_in) && !bus_in.we |-> ##[1:2] status_byte_out[4:2] == 3'b000)
    else $error("acknowledge did not clear status");
  chk_unused_bits: assert property (status_byte_out[7:5] == 3'b000 && status_byte_out[1:0] == 2'b00)
    else $error("unused status bit set");
  chk_warn_set: assert property ($rose(selftest_warning_in) |-> ##[1:2] status_byte_out[2])
    else $error("warning flag not set");
  chk_fail_set: assert property ($rose(selftest_failure_in) |-> ##[1:2] status_byte_out[3])
    else $error("failure flag not set");
  chk_settings_set: assert property (settings_change_in |-> ##[1:2] status_byte_out[4])
    else $error("settings flag not set");
  chk_diag_clear: assert property (diag_pass_in && !selftest_warning_in && !selftest_failure_in
    && !$past(selftest_warning_in) && !$past(selftest_failure_in) |-> ##[1:2] status_byte_out[3:2] == 2'b00)
    else $error("diagnostics pass did not clear flags");
  chk_diag_keeps: assert property (diag_pass_in && status_byte_out[4] && !rx_in.valid && !$past(rx_in.valid)
    && !$past(rx_in.valid, 2) |=> status_byte_out[4])
    else $error("diagnostics pass cleared settings flag");
  chk_defn_start: assert property (s_req(REQ_DEFN) |-> ##[1:40] tx_out.valid && tx_out.data == REQ_LEAD)
    else $error("definition block did not start");
  cover property (s_req(REQ_DEFN));
  cover property (s_req(REQ_MDAT));
  cover property (s_req(REQ_ACK));
endmodule // bmmr_responder_checker
bind bmmr_responder bmmr_responder_checker u_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus_in),
  .bus_rdata_out(bus_rdata_out), .rx_in(rx_in), .ascii_in(ascii_in), .ascii_ready_out(ascii_ready_out),
  .tx_out(tx_out), .tx_ready_in(tx_ready_in), .selftest_warning_in(selftest_warning_in),
  .selftest_failure_in(selftest_failure_in), .diag_pass_in(diag_pass_in),
  .settings_change_in(settings_change_in), .status_byte_out(status_byte_out));
`default_nettype wire

/* File: bmmr_tb_top.sv */
`default_nettype none
module binary_metering_message_responder_tb_top import bmmr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [327:0] DEFN = {80'ha5c02a020103a5c1a5d1, 64'h00025354410d0000, 64'h00035354410d0000,
    64'h0004a5c100000000, 56'h01000101000500};
  localparam logic [79:0] OHDR = 80'ha5ce3c01001001003111;
  localparam logic [127:0] MHDR = 128'ha5c19401010309045002_0004004c0054;
  localparam logic [95:0] CIDX = 96'h010407000306_ffffff020508;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  bmmr_bus_t bus = '0;
  bmmr_byte_t ascii = '0;
  bmmr_byte_t rx;
  bmmr_byte_t tx;
  logic [31:0] rdata;
  logic ascii_rdy, tx_rdy;
  logic rdv = 1'b0, in_blk = 1'b0;
  logic warn = 1'b0, fail = 1'b0, diag = 1'b0, setc = 1'b0;
  logic [7:0] status, sum;
  logic [9:0] e;
  logic [7:0] pay [160];
  logic [95:0] sf;
  int fails = 0, checks_done = 0;
  logic [9:0] blkq [$];
  logic [7:0] ascq [$];
  logic [31:0] rdq [$];
  initial forever #25 sys_clk_in = ~sys_clk_in;
  bmmr_responder DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus), .bus_rdata_out(rdata), .rx_in(rx),
    .ascii_in(ascii), .ascii_ready_out(ascii_rdy), .tx_out(tx), .tx_ready_in(tx_rdy), .selftest_warning_in(warn),
    .selftest_failure_in(fail), .diag_pass_in(diag), .settings_change_in(setc), .status_byte_out(status));
  bmmr_host_model host (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .rx_out(rx), .tx_ready_out(tx_rdy));
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (!ok) begin
      fails++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    tick();
    bus <= '{a, d, 1'b1, 1'b0};
    tick();
    bus <= '0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] x);
    rdq.push_back(x);
    tick();
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    tick();
    bus <= '0;
  endtask
  task automatic nb(input logic [7:0] v, input logic c = 1'b1);
    blkq.push_back({1'b0, c, v});
  endtask
  task automatic ncs;
    blkq.push_back(10'h200);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while ((blkq.size() > 0 || ascq.size() > 0 || in_blk) && n < 3000) begin
      tick();
      n++;
    end
    chk(n < 3000, "block did not drain");
    tick(8);
  endtask
  task automatic push_defn;
    for (int i = 0; i < 41; i++) nb(DEFN[327-8*i -: 8]);
    ncs();
  endtask
  task automatic push_mcfg(input logic rot, input logic [95:0] s);
    logic [8:0] m [148];
    int b;
    for (int i = 0; i < 148; i++) m[i] = 9'h0;
    for (int i = 0; i < 16; i++) m[i] = {1'b1, MHDR[127-8*i -: 8]};
    for (int c = 0; c < 9; c++) begin
      b = 16 + 10 * c;
      m[b] = {1'b1, (c % 3 == 1) ? 8'h49 : 8'h56};
      m[b+1] = {1'b1, 8'h41 + 8'(c / 3)};
      m[b+2] = {1'b1, (c % 3 == 0) ? 8'h58 : (c % 3 == 2) ? 8'h59 : 8'h00};
      for (int j = 3; j < 9; j++) m[b+j] = 9'h100;
      m[b+7] = 9'h101;
      m[b+9] = {1'b1, (c % 3 == 0) ? 8'h8a : (c % 3 == 1) ? 8'h86 : 8'h8e};
    end
    for (int k = 0; k < 2; k++) begin
      b = 106 + 14 * k;
      m[b] = {1'b1, 7'h0, rot};
      m[b+1] = (k == 1) ? 9'h102 : 9'h100;
      for (int j = 2; j < 8; j++) m[b+j] = 9'h1ff;
      for (int j = 0; j < 6; j++) m[b+8+j] = {1'b1, CIDX[95-48*k-8*j -: 8]};
    end
    for (int j = 0; j < 12; j++) m[134+j] = {1'b1, s[95-8*j -: 8]};
    m[146] = 9'h100;
    for (int i = 0; i < 147; i++) nb(m[i][7:0], m[i][8]);
    ncs();
  endtask
  task automatic ascii_send(input int n);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = 8'h20 + 8'($urandom_range(94));
      ascii <= '{1'b1, b};
      do tick(); while (ascii_rdy !== 1'b1);
      ascq.push_back(b);
    end
    ascii <= '{1'b0, ~b};
  endtask
  // Printable ascii never equals the lead byte, so a lead starts a block
  always @(posedge sys_clk_in) begin
    if (!rst_in && tx.valid && tx_rdy === 1'b1) begin
      if (!in_blk && !(tx.data === REQ_LEAD && blkq.size() > 0)) begin
        if (ascq.size() == 0) chk(1'b0, "unexpected tx byte");
        else chk(tx.data === ascq.pop_front(), "ascii byte");
      end else begin
        if (!in_blk) sum = 8'h0;
        in_blk = 1'b1;
        e = blkq.pop_front();
        if (e[9]) chk(tx.data === sum, "checksum");
        else if (e[8]) chk(tx.data === e[7:0], "block byte");
        sum = sum + tx.data;
        if (e[9]) in_blk = 1'b0;
      end
    end
    if (rdv) chk(rdata === rdq.pop_front(), "read data");
    rdv = bus.re;
  end
  initial begin
    #(20000 * 50);
    chk(1'b0, "watchdog expired");
    test_done();
  end
  initial begin
    void'($urandom(32'hf215));
    tick(10);
    rst_in <= 1'b0;
    tick(2);
    chk(status === 8'h10, "power-up status");
    host.req(REQ_LEAD, REQ_ACK);
    wait_idle();
    chk(status === 8'h00, "acknowledge clear");
    host.req(REQ_LEAD, 8'hc2);
    host.req(REQ_LEAD, 8'he0);
    host.req(8'h5a, REQ_DEFN);
    wait_idle();
    $display("test status and ignore done");
    push_defn();
    host.req(REQ_LEAD, REQ_DEFN);
    wait_idle();
    for (int i = 0; i < 10; i++) nb(OHDR[79-8*i -: 8]);
    for (int n = 0; n < 16; n++) begin
      nb(8'(n));
      nb(8'h20 + 8'(n));
      nb(8'h40 + 8'(n));
    end
    nb(8'h00);
    ncs();
    host.req(REQ_LEAD, REQ_OCFG);
    wait_idle();
    $display("test fixed blocks done");
    warn <= 1'b1;
    tick(3);
    chk(status === 8'h04, "warning flag");
    host.req(REQ_LEAD, REQ_ACK);
    wait_idle();
    chk(status === 8'h00, "ack with condition held");
    fail <= 1'b1;
    setc <= 1'b1;
    tick();
    setc <= 1'b0;
    tick(3);
    chk(status === 8'h18, "failure and settings flags");
    warn <= 1'b0;
    fail <= 1'b0;
    tick(2);
    diag <= 1'b1;
    tick();
    diag <= 1'b0;
    tick(3);
    chk(status === 8'h10, "diagnostics pass");
    $display("test flags done");
    sf = {$urandom, $urandom, $urandom};
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_SF_I, sf[95:64]);
    wr(ADDR_SF_X, sf[63:32]);
    wr(ADDR_SF_Y, sf[31:0]);
    rd(ADDR_SF_X, sf[63:32]);
    rd(10'h3fc, 32'h0);
    rd(ADDR_CTRL, 32'h1);
    rd(ADDR_STATUS, 32'h10);
    // settings flag seen, host rereads configuration
    push_mcfg(1'b1, sf);
    host.req(REQ_LEAD, REQ_MCFG);
    wait_idle();
    $display("test configuration done");
    host.req(REQ_LEAD, REQ_ACK);
    for (int i = 0; i < 160; i++) begin
      pay[i] = 8'($urandom);
      wr(ADDR_PAY_BASE + 10'(4 * i), {24'h0, pay[i]});
    end
    rd(ADDR_PAY_BASE + 10'd636, {24'h0, pay[159]});
    warn <= 1'b1;
    tick(3);
    nb(REQ_LEAD);
    nb(REQ_MDAT);
    nb(LEN_MDAT);
    nb(8'h04);
    for (int i = 0; i < 160; i++) nb(pay[i]);
    nb(8'h00);
    ncs();
    host.req(REQ_LEAD, REQ_MDAT);
    wait_idle();
    $display("test data block done");
    fork
      ascii_send(16);
      begin
        tick(6);
        push_defn();
        host.req(REQ_LEAD, REQ_DEFN);
      end
    join
    wait_idle();
    chk(ascii_rdy === 1'b1, "ascii stream resumed");
    $display("test interleave done");
    test_done();
  end
endmodule // binary_metering_message_responder_tb_top
`default_nettype wire
